// [dv/cpsr_host.sv]
`timescale 1ns/1ns
module cpsr_host (
	input  wire logic sys_clk,
	output logic       reg_wr,
	output logic       reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// The write strobe drops on the next edge, so writes never overlap reads
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// Burst of n reads held back to back on one address
	task automatic rd(input logic [7:0] a, input int n);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		repeat (n) @(posedge sys_clk);
		reg_rd <= 1'b0;
	endtask
endmodule

// [dv/cpsr_tb.sv]
`timescale 1ns/1ns
module testbench;
	logic        sys_clk = 0, nrst = 0, rand_load = 0, rx_status_load = 0;
	logic        rx_repeater = 0, rx_features = 0, rx_unencrypted_reauth = 0;
	logic        rx_max_devices = 0, rx_max_cascade = 0, list_clear = 0, list_wr = 0;
	logic        list_done = 0, frame_start = 0, pix_valid = 0, line_end = 0, rd_seen = 0;
	logic [15:0] rand_hi = 0;
	logic [6:0]  rx_device_count = 0;
	logic [2:0]  rx_cascade_depth = 0;
	logic [7:0]  list_wdata = 0, reg_addr, reg_wdata, reg_rdata;
	logic [23:0] pix_data = 0, sum_data;
	logic        reg_wr, reg_rd, sum_valid, pj_due, ri_due;
	logic        auth_timer_speedup, protocol_master_fast_timing, indirect_status_fast_timing;
	logic [23:0] rq[$], sq[$];
	int          err_total = 0, total_checks = 0, npj = 0, nri = 0;

	initial forever #2 sys_clk = ~sys_clk;

	cpsr_host host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata));
	cpsr_regs dut (.sys_clk(sys_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.rand_load(rand_load), .rand_hi(rand_hi), .rx_status_load(rx_status_load),
		.rx_repeater(rx_repeater), .rx_features(rx_features),
		.rx_unencrypted_reauth(rx_unencrypted_reauth), .rx_device_count(rx_device_count),
		.rx_max_devices(rx_max_devices), .rx_cascade_depth(rx_cascade_depth),
		.rx_max_cascade(rx_max_cascade), .list_clear(list_clear), .list_wr(list_wr),
		.list_wdata(list_wdata), .list_done(list_done), .frame_start(frame_start),
		.pix_valid(pix_valid), .pix_data(pix_data), .line_end(line_end),
		.sum_valid(sum_valid), .sum_data(sum_data), .pj_due(pj_due), .ri_due(ri_due),
		.auth_timer_speedup(auth_timer_speedup),
		.protocol_master_fast_timing(protocol_master_fast_timing),
		.indirect_status_fast_timing(indirect_status_fast_timing));

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string m);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %0t %s", $time, m);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic rdx(input logic [7:0] a, input logic [7:0] e);
		rq.push_back({16'h0000, e});
		host.rd(a, 1);
	endtask

	// End-around carry keeps the sum within eight bits per channel
	function automatic logic [23:0] csum(input logic [23:0] a, input logic [23:0] b);
		logic [8:0]  s;
		logic [23:0] r;
		for (int c = 0; c < 3; c++) begin
			s = a[c*8+:8] + b[c*8+:8];
			r[c*8+:8] = ~(s[7:0] + {7'h00, s[8]});
		end
		return r;
	endfunction

	task automatic frames(input int n);
		repeat (n) begin
			@(posedge sys_clk) frame_start <= 1'b1;
			@(posedge sys_clk) frame_start <= 1'b0;
		end
		repeat (2) @(posedge sys_clk);
	endtask

	always @(posedge sys_clk) begin
		rd_seen <= reg_rd;
		if (pj_due === 1'b1) npj++;
		if (ri_due === 1'b1) nri++;
	end

	// Empty read queue yields an impossible byte so a stray read is caught; an empty sum queue expects zero
	always @(negedge sys_clk) begin
		if (rd_seen) chk(reg_rdata, rq.size() ? rq.pop_front() : 24'hFFFFFF, "read");
		if (sum_valid === 1'b1) chk(sum_data, sq.size() ? sq.pop_front() : 24'h0, "sum");
	end

	initial begin
		#40000;
		err_total++;
		wrap_up();
	end

	initial begin
		logic [7:0]  ofs[8];
		logic [7:0]  lb[3];
		logic [7:0]  dv[3];
		logic [31:0] r;
		logic [23:0] pa, pb;
		int          p0, r0;
		ofs = '{8'h9E, 8'h9F, 8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hC0, 8'h00};
		dv = '{8'hF6, 8'h09, 8'h0C};
		void'($urandom(39599));
		repeat (12) @(posedge sys_clk);
		nrst <= 1'b1;
		foreach (ofs[i]) rdx(ofs[i], 8'h00);
		$display("test reset values done");
		@(posedge sys_clk) rand_hi <= 16'($urandom);
		rand_load <= 1'b1;
		@(posedge sys_clk) rand_load <= 1'b0;
		host.wr(8'h9E, ~rand_hi[7:0]);
		rdx(8'h9E, rand_hi[7:0]);
		rdx(8'h9F, rand_hi[15:8]);
		$display("test random bytes done");
		for (int k = 0; k < 2; k++) begin
			r = $urandom;
			@(posedge sys_clk) rx_status_load <= 1'b1;
			{rx_max_devices, rx_device_count, rx_max_cascade, rx_cascade_depth} <= r[11:0];
			{rx_features, rx_unencrypted_reauth} <= r[13:12];
			rx_repeater <= k[0];
			@(posedge sys_clk) rx_status_load <= 1'b0;
			rdx(8'hA0, {1'b0, rx_repeater, 4'h0, rx_features, rx_unencrypted_reauth});
			rdx(8'hA1, {rx_max_devices, k ? rx_device_count : 7'h00});
			rdx(8'hA2, {4'h0, rx_max_cascade, rx_cascade_depth});
		end
		$display("test receiver status done");
		@(posedge sys_clk) list_clear <= 1'b1;
		@(posedge sys_clk) list_clear <= 1'b0;
		foreach (lb[i]) begin
			lb[i] = 8'($urandom);
			@(posedge sys_clk) list_wr <= 1'b1;
			list_wdata <= lb[i];
		end
		@(posedge sys_clk) list_wr <= 1'b0;
		list_done <= 1'b1;
		@(posedge sys_clk) list_done <= 1'b0;
		rdx(8'hA0, {2'b01, 4'h8, rx_features, rx_unencrypted_reauth});
		foreach (lb[i]) rq.push_back({16'h0000, lb[i]});
		host.rd(8'hA3, 3);
		$display("test key list done");
		foreach (dv[i]) begin
			host.wr(8'hC0, dv[i]);
			rdx(8'hC0, dv[i] & 8'h0F);
			@(negedge sys_clk);
			chk({23'h0, auth_timer_speedup}, {23'h0, dv[i][1]}, "speedup");
			chk({23'h0, protocol_master_fast_timing}, {23'h0, dv[i][0]}, "fast");
			chk({23'h0, indirect_status_fast_timing}, {23'h0, dv[i][0]}, "mirror");
		end
		$display("test debug control done");
		for (int k = 0; k < 2; k++) begin
			pa = 24'($urandom);
			pb = 24'($urandom);
			if (k == 0) sq.push_back(csum(pa, pb));
			else host.wr(8'hC0, 8'h04);
			@(posedge sys_clk) pix_valid <= 1'b1;
			pix_data <= pa;
			@(posedge sys_clk) pix_data <= pb;
			@(posedge sys_clk) pix_valid <= 1'b0;
			line_end <= 1'b1;
			@(posedge sys_clk) line_end <= 1'b0;
			repeat (3) @(posedge sys_clk);
		end
		chk(24'(sq.size()), 24'h000000, "sum count");
		$display("test line sum done");
		p0 = npj;
		r0 = nri;
		frames(32);
		chk(24'(npj - p0), 24'h000010, "fast pj");
		chk(24'(nri - r0), 24'h000002, "fast ri");
		host.wr(8'hC0, 8'h00);
		p0 = npj;
		r0 = nri;
		frames(128);
		chk(24'(npj - p0), 24'h000008, "slow pj");
		chk(24'(nri - r0), 24'h000001, "slow ri");
		$display("test verify rate done");
		wrap_up();
	end
endmodule

// [logic/cpsr_cfg.svh]
`ifndef CPSR_CFG_SVH
`define CPSR_CFG_SVH
`define CPSR_OFS_RAND6      8'h9E
`define CPSR_OFS_RAND7      8'h9F
`define CPSR_OFS_CAPS       8'hA0
`define CPSR_OFS_TOPO_LO    8'hA1
`define CPSR_OFS_TOPO_HI    8'hA2
`define CPSR_OFS_LST_PORT   8'hA3
`define CPSR_OFS_DBG        8'hC0
`define CPSR_RST_BYTE       8'h00
`define CPSR_CAPS_MASK      8'h63
`define CPSR_TOPO_HI_MASK   8'h0F
`define CPSR_DBG_MASK       8'h0F
`define CPSR_BIT_CAPS_RPT   6
`define CPSR_BIT_CAPS_LIST  5
`define CPSR_BIT_CAPS_FEAT  1
`define CPSR_BIT_CAPS_REAU  0
`define CPSR_BIT_TOPO_MAXD  7
`define CPSR_BIT_TOPO_MAXC  3
`define CPSR_BIT_DBG_CHK    3
`define CPSR_BIT_DBG_FLV    2
`define CPSR_BIT_DBG_TMR    1
`define CPSR_BIT_DBG_I2C    0
`define CPSR_PJ_FAST        8'h02
`define CPSR_RI_FAST        8'h10
`define CPSR_PJ_SLOW        8'h10
`define CPSR_RI_SLOW        8'h80
`define CPSR_MAX_CASCADE    3'h7
`define CPSR_LIST_DEPTH     128
`define CPSR_LIST_AW        7
`endif

// [logic/cpsr_frame_rate.sv]
`timescale 1ns/1ns
`include "cpsr_cfg.svh"
module cpsr_frame_rate (
	input  wire logic sys_clk,
	input  wire logic nrst,
	input  wire logic fast,
	input  wire logic frame_start,
	output logic      pj_due,
	output logic      ri_due
);
	logic [7:0] frame_cnt;
	logic [7:0] pj_period;
	logic [7:0] ri_period;

	assign pj_period = fast ? `CPSR_PJ_FAST : `CPSR_PJ_SLOW;
	assign ri_period = fast ? `CPSR_RI_FAST : `CPSR_RI_SLOW;

	// Free count; periods are powers of two so a mask picks the boundary
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			frame_cnt <= 8'h00;
		end else if (frame_start) begin
			frame_cnt <= frame_cnt + 8'h01;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			pj_due <= 1'b0;
			ri_due <= 1'b0;
		end else begin
			pj_due <= frame_start && ((frame_cnt & (pj_period - 8'h01)) == 8'h00);
			ri_due <= frame_start && ((frame_cnt & (ri_period - 8'h01)) == 8'h00);
		end
	end
endmodule

// [logic/cpsr_line_sum.sv]
`timescale 1ns/1ns
module cpsr_line_sum (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        enable,
	input  wire logic        pix_valid,
	input  wire logic [23:0] pix_data,
	input  wire logic        line_end,
	output logic             sum_valid,
	output logic [23:0]      sum_data
);
	logic [7:0] acc [3];

	function automatic logic [7:0] cpsr_oc_add(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[7:0] + {7'h00, s[8]};
	endfunction

	always_ff @(posedge sys_clk) begin
		if (!nrst || line_end) begin
			for (int i = 0; i < 3; i++) begin
				acc[i] <= 8'h00;
			end
		end else if (pix_valid) begin
			for (int i = 0; i < 3; i++) begin
				acc[i] <= cpsr_oc_add(acc[i], pix_data[i*8 +: 8]);
			end
		end
	end

	// Sum goes out complemented, one cycle after line end
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			sum_valid <= 1'b0;
			sum_data  <= 24'h000000;
		end else begin
			sum_valid <= enable && line_end;
			if (enable && line_end) begin
				sum_data <= ~{acc[2], acc[1], acc[0]};
			end
		end
	end
endmodule

// [logic/cpsr_pkg.sv]
package cpsr_pkg;
	typedef logic [7:0] cpsr_byte_t;
	typedef enum logic [1:0] {
		CPSR_LIST_IDLE,
		CPSR_LIST_FILL,
		CPSR_LIST_READY
	} cpsr_list_state_t;
endpackage

// [logic/cpsr_regs.sv]
`timescale 1ns/1ns
`include "cpsr_cfg.svh"
// Notes on behaviour
// - Random bytes six, seven read-only, reset zero
// - Repeater capability bit, readable once receiver status loads
// - Read-only key list ready flag
// - Read-only enhanced features support flag
// - Read-only unencrypted-during-reauth support flag
// - Flag when devices exceed list capacity
// - Seven-bit device count, zero for non-repeater
// - Flag when cascade deeper than seven
// - Three-bit cascade depth field
// - Each list port read returns next byte, zero when list empty
// - Line checksum per channel when enabled
// - Fast verify: Pj per 2, Ri per 16
// - Normal verify: Pj per 16, Ri per 128
// - Speedup bit shortens authentication timers
// - Fast bit selects protocol master timing
// - Fast timing bit mirrored in indirect status
module cpsr_regs (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic [7:0]       reg_rdata,
	input  wire logic        rand_load,
	input  wire logic [15:0] rand_hi,
	input  wire logic        rx_status_load,
	input  wire logic        rx_repeater,
	input  wire logic        rx_features,
	input  wire logic        rx_unencrypted_reauth,
	input  wire logic [6:0]  rx_device_count,
	input  wire logic        rx_max_devices,
	input  wire logic [2:0]  rx_cascade_depth,
	input  wire logic        rx_max_cascade,
	input  wire logic        list_clear,
	input  wire logic        list_wr,
	input  wire logic [7:0]  list_wdata,
	input  wire logic        list_done,
	input  wire logic        frame_start,
	input  wire logic        pix_valid,
	input  wire logic [23:0] pix_data,
	input  wire logic        line_end,
	output logic             sum_valid,
	output logic [23:0]      sum_data,
	output logic             pj_due,
	output logic             ri_due,
	output logic             auth_timer_speedup,
	output logic             protocol_master_fast_timing,
	output logic             indirect_status_fast_timing
);
	cpsr_pkg::cpsr_byte_t session_random_byte6;
	cpsr_pkg::cpsr_byte_t session_random_byte7;
	cpsr_pkg::cpsr_byte_t receiver_capabilities;
	cpsr_pkg::cpsr_byte_t receiver_topology_status_lo;
	cpsr_pkg::cpsr_byte_t receiver_topology_status_hi;
	cpsr_pkg::cpsr_byte_t protection_debug_control;
	cpsr_pkg::cpsr_list_state_t list_state;
	cpsr_pkg::cpsr_byte_t list_mem [`CPSR_LIST_DEPTH];
	logic [`CPSR_LIST_AW-1:0] list_wptr;
	logic [`CPSR_LIST_AW-1:0] list_rptr;
	logic [`CPSR_LIST_AW:0]   list_count;
	logic                     list_ready;
	logic                     port_rd;
	logic                     list_push;
	logic                     list_pop;
	logic                     line_checksum_enable;
	logic                     fast_link_verify;
	cpsr_pkg::cpsr_byte_t     next_rdata;

	assign list_ready = (list_state == cpsr_pkg::CPSR_LIST_READY);
	assign port_rd    = reg_rd && (reg_addr == `CPSR_OFS_LST_PORT);
	// Full list drops the byte whole; a wrapped write would clobber the oldest entry
	assign list_push  = list_wr && list_state != cpsr_pkg::CPSR_LIST_READY
	                    && list_count != (`CPSR_LIST_AW+1)'(`CPSR_LIST_DEPTH);
	assign list_pop   = port_rd && list_count != '0;

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			session_random_byte6 <= `CPSR_RST_BYTE;
			session_random_byte7 <= `CPSR_RST_BYTE;
		end else if (rand_load) begin
			session_random_byte6 <= rand_hi[7:0];
			session_random_byte7 <= rand_hi[15:8];
		end
	end

	// Status captured from the receiver's answers; writes never touch it
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			receiver_capabilities       <= `CPSR_RST_BYTE;
			receiver_topology_status_lo <= `CPSR_RST_BYTE;
			receiver_topology_status_hi <= `CPSR_RST_BYTE;
		end else if (rx_status_load) begin
			receiver_capabilities[`CPSR_BIT_CAPS_RPT]  <= rx_repeater;
			receiver_capabilities[`CPSR_BIT_CAPS_FEAT] <= rx_features;
			receiver_capabilities[`CPSR_BIT_CAPS_REAU] <= rx_unencrypted_reauth;
			receiver_topology_status_lo[`CPSR_BIT_TOPO_MAXD] <= rx_max_devices;
			receiver_topology_status_lo[6:0] <= rx_repeater ? rx_device_count : 7'h00;
			receiver_topology_status_hi[`CPSR_BIT_TOPO_MAXC] <= rx_max_cascade;
			receiver_topology_status_hi[2:0] <= rx_cascade_depth;
		end
	end

	// Key list: filled by the link side, drained one byte per port read
	always_ff @(posedge sys_clk) begin
		if (!nrst || list_clear) begin
			list_state <= cpsr_pkg::CPSR_LIST_IDLE;
		end else begin
			case (list_state)
				cpsr_pkg::CPSR_LIST_IDLE: begin
					if (list_wr) begin
						list_state <= cpsr_pkg::CPSR_LIST_FILL;
					end
				end
				cpsr_pkg::CPSR_LIST_FILL: begin
					if (list_done) begin
						list_state <= cpsr_pkg::CPSR_LIST_READY;
					end
				end
				cpsr_pkg::CPSR_LIST_READY: begin
				end
				default: begin
					list_state <= cpsr_pkg::CPSR_LIST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (list_push) begin
			list_mem[list_wptr] <= list_wdata;
		end
	end

	// Push and pop may share a cycle, so a port read on a non-empty list still advances
	always_ff @(posedge sys_clk) begin
		if (!nrst || list_clear) begin
			list_wptr  <= '0;
			list_rptr  <= '0;
			list_count <= '0;
		end else begin
			if (list_push) begin
				list_wptr <= list_wptr + 1'b1;
			end
			if (list_pop) begin
				list_rptr <= list_rptr + 1'b1;
			end
			if (list_push && !list_pop) begin
				list_count <= list_count + 1'b1;
			end else if (list_pop && !list_push) begin
				list_count <= list_count - 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			protection_debug_control <= `CPSR_RST_BYTE;
		end else if (reg_wr && reg_addr == `CPSR_OFS_DBG) begin
			protection_debug_control <= reg_wdata & `CPSR_DBG_MASK;
		end
	end

	assign line_checksum_enable        = protection_debug_control[`CPSR_BIT_DBG_CHK];
	assign fast_link_verify            = protection_debug_control[`CPSR_BIT_DBG_FLV];
	assign auth_timer_speedup          = protection_debug_control[`CPSR_BIT_DBG_TMR];
	assign protocol_master_fast_timing = protection_debug_control[`CPSR_BIT_DBG_I2C];
	assign indirect_status_fast_timing = protection_debug_control[`CPSR_BIT_DBG_I2C];

	always_comb begin
		next_rdata = 8'h00;
		case (reg_addr)
			`CPSR_OFS_RAND6:    next_rdata = session_random_byte6;
			`CPSR_OFS_RAND7:    next_rdata = session_random_byte7;
			`CPSR_OFS_CAPS: begin
				next_rdata = receiver_capabilities & `CPSR_CAPS_MASK;
				next_rdata[`CPSR_BIT_CAPS_LIST] = list_ready;
			end
			`CPSR_OFS_TOPO_LO:  next_rdata = receiver_topology_status_lo;
			`CPSR_OFS_TOPO_HI:  next_rdata = receiver_topology_status_hi & `CPSR_TOPO_HI_MASK;
			`CPSR_OFS_LST_PORT: next_rdata = (list_count != '0) ? list_mem[list_rptr] : 8'h00;
			`CPSR_OFS_DBG:      next_rdata = protection_debug_control;
			default:            next_rdata = 8'h00;
		endcase
	end

	// Read data registered; port address pops in the same read cycle
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end
	end

	cpsr_line_sum u_line_sum (
		.sys_clk   (sys_clk),
		.nrst      (nrst),
		.enable    (line_checksum_enable),
		.pix_valid (pix_valid),
		.pix_data  (pix_data),
		.line_end  (line_end),
		.sum_valid (sum_valid),
		.sum_data  (sum_data)
	);

	cpsr_frame_rate u_frame_rate (
		.sys_clk     (sys_clk),
		.nrst        (nrst),
		.fast        (fast_link_verify),
		.frame_start (frame_start),
		.pj_due      (pj_due),
		.ri_due      (ri_due)
	);

	chk_dbg_reserved_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
		protection_debug_control[7:4] == 4'h0) else $error("debug reserved bits set");
	chk_dbg_write_lands: assert property (@(posedge sys_clk) disable iff (!nrst)
		reg_wr && reg_addr == `CPSR_OFS_DBG |=> protection_debug_control == ($past(reg_wdata) & 8'h0F))
		else $error("debug write lost");
	chk_mirror_equal: assert property (@(posedge sys_clk) disable iff (!nrst)
		indirect_status_fast_timing == protocol_master_fast_timing) else $error("mirror differs");
	chk_count_non_rpt: assert property (@(posedge sys_clk) disable iff (!nrst)
		rx_status_load && !rx_repeater |=> receiver_topology_status_lo[6:0] == 7'h00)
		else $error("count nonzero for non-repeater");
	chk_count_captured: assert property (@(posedge sys_clk) disable iff (!nrst)
		rx_status_load && rx_repeater |=> receiver_topology_status_lo[6:0] == $past(rx_device_count))
		else $error("device count not captured");
	chk_rand_capture: assert property (@(posedge sys_clk) disable iff (!nrst)
		rand_load |=> {session_random_byte7, session_random_byte6} == $past(rand_hi))
		else $error("random bytes not captured");
	chk_port_advance: assert property (@(posedge sys_clk) disable iff (!nrst)
		port_rd && list_count != '0 && !list_clear |=> list_rptr == $past(list_rptr) + 1'b1)
		else $error("list port did not advance");
	chk_port_empty_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
		reg_rd && reg_addr == `CPSR_OFS_LST_PORT && list_count == '0 |=> reg_rdata == 8'h00)
		else $error("empty list port not zero");
	chk_list_ready_flag: assert property (@(posedge sys_clk) disable iff (!nrst)
		list_state == cpsr_pkg::CPSR_LIST_FILL && list_done && !list_clear |=> list_ready)
		else $error("list ready not set");
	chk_list_clear_flag: assert property (@(posedge sys_clk) disable iff (!nrst)
		list_clear |=> !list_ready) else $error("list ready survived clear");
	chk_caps_reserved_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
		reg_rd && reg_addr == `CPSR_OFS_CAPS |=> (reg_rdata & 8'h9C) == 8'h00)
		else $error("capability reserved bits set");
	chk_sum_on_line_end: assert property (@(posedge sys_clk) disable iff (!nrst)
		line_checksum_enable && line_end |=> sum_valid) else $error("checksum missing");
	chk_slow_pj_gap: assert property (@(posedge sys_clk) disable iff (!nrst)
		pj_due && !fast_link_verify |=> !pj_due) else $error("pj too often");
	chk_ri_with_pj: assert property (@(posedge sys_clk) disable iff (!nrst)
		ri_due |-> pj_due) else $error("ri off a pj boundary");
	chk_cascade_flag: assert property (@(posedge sys_clk) disable iff (!nrst)
		rx_status_load |=> receiver_topology_status_hi[3] == $past(rx_max_cascade))
		else $error("cascade flag wrong");
endmodule
